//--- obwc_top.sv
// Peripheral bus window decode and bus cycle controller.
`timescale 1ns/1ps
`include "obwc_regs.svh"

module obwc_top import obwc_pkg::*; (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // Register port
  input  wire logic [15:0] sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic [15:0] sfr_wdata,
  input  wire logic        sfr_bset,
  input  wire logic        sfr_bclr,
  input  wire logic [3:0]  sfr_bit,
  input  wire logic        sfr_rd,
  output logic [15:0]      sfr_rdata,
  // CPU access
  input  wire logic        acc_req,
  input  wire logic [23:0] acc_addr,
  input  wire logic        acc_write,
  input  wire logic [15:0] acc_wdata,
  output logic             acc_ready,
  output logic             acc_hit,
  output logic             acc_done,
  output logic [15:0]      acc_rdata,
  // Peripheral bus
  output logic [1:0]       per_cs,
  output logic             per_ale,
  output logic             per_rd,
  output logic             per_wr,
  output logic             per_wide,
  output logic             per_float,
  output logic [23:0]      per_addr,
  output logic [15:0]      per_wdata,
  input  wire logic [15:0] per_rdata,
  input  wire logic        per_ready,
  // External bus
  output logic             ext_quiet,
  output logic             ext_go
);

  // ****************************************
  // State and sub-blocks
  // ****************************************
  obwc_core_s  c;
  obwc_core_s  next_c;
  logic        dec_hit;
  logic        dec_win;
  logic        tmr_zero;
  logic        tmr_load;
  logic [4:0]  tmr_val;
  logic [15:0] cw;
  logic [15:0] nw;
  logic        need_sw;
  logic        strobe_end;
  logic        active;

  // Window 0 serves the telecom highway, window 1 the USB module.
  obwc_window_decode u_dec (
    .addr  (acc_addr),
    .sel0  (c.sel[0]),
    .sel1  (c.sel[1]),
    .ctrl0 (c.ctrl[0]),
    .ctrl1 (c.ctrl[1]),
    .hit   (dec_hit),
    .win   (dec_win)
  );

  obwc_cycle_timer u_tmr (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .load     (tmr_load),
    .load_val (tmr_val),
    .zero     (tmr_zero)
  );

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic [15:0] reg_upd(input logic [15:0] old,
                                          input logic [15:0] adr,
                                          input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (sfr_addr == adr) begin
      if (sfr_wr) begin
        v = sfr_wdata;
      end else if (sfr_bset) begin
        v[sfr_bit] = 1'b1;
      end else if (sfr_bclr) begin
        v[sfr_bit] = 1'b0;
      end
    end
    reg_upd = v & mask;
  endfunction

  function automatic logic [4:0] ale_val(input logic [15:0] r);
    ale_val = r[`OBWC_ALEL] ? `OBWC_ALE_XTRA : `OBWC_ZERO5;
  endfunction

  function automatic logic [4:0] strobe_val(input logic [15:0] r);
    if (r[`OBWC_RDY]) begin
      strobe_val = `OBWC_RDY_MIN;
    end else begin
      strobe_val = {1'b0, r[`OBWC_WAIT]} + `OBWC_STRB_BASE;
    end
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    cw = c.ctrl[c.win];
    nw = c.ctrl[dec_win];
    // Switch wait comes from the register of the previous cycle.
    need_sw = c.last_valid && c.last_bsw
              && (c.last_win != dec_win);
    strobe_end = cw[`OBWC_RDY] ? (tmr_zero && per_ready)
                               : tmr_zero;
  end

  always_comb begin
    next_c        = c;
    next_c.ext_go = 1'b0;
    tmr_load      = 1'b0;
    tmr_val       = `OBWC_ZERO5;
    next_c.ctrl[0] = reg_upd(c.ctrl[0], `OBWC_CTRL0_ADR,
                             `OBWC_CTRL_MASK);
    next_c.ctrl[1] = reg_upd(c.ctrl[1], `OBWC_CTRL1_ADR,
                             `OBWC_CTRL_MASK);
    next_c.sel[0]  = reg_upd(c.sel[0], `OBWC_SEL0_ADR,
                             `OBWC_SEL_MASK);
    next_c.sel[1]  = reg_upd(c.sel[1], `OBWC_SEL1_ADR,
                             `OBWC_SEL_MASK);
    if (sfr_rd) begin
      unique case (sfr_addr)
        `OBWC_CTRL0_ADR: next_c.sfr_rdata = c.ctrl[0];
        `OBWC_CTRL1_ADR: next_c.sfr_rdata = c.ctrl[1];
        `OBWC_SEL0_ADR:  next_c.sfr_rdata = c.sel[0];
        `OBWC_SEL1_ADR:  next_c.sfr_rdata = c.sel[1];
        default:         next_c.sfr_rdata = `OBWC_ZERO16;
      endcase
    end
    unique case (c.st)
      OBWC_IDLE: begin
        if (acc_req && dec_hit) begin
          // A window hit takes the access away from external decode.
          next_c.win   = dec_win;
          next_c.wr    = acc_write;
          next_c.addr  = acc_addr;
          next_c.wdata = acc_wdata;
          if (need_sw) begin
            next_c.st = OBWC_SWITCH;
          end else begin
            next_c.st = OBWC_LATCH;
            tmr_load  = 1'b1;
            tmr_val   = ale_val(nw);
          end
        end else if (acc_req) begin
          next_c.ext_go = 1'b1;
        end
      end
      OBWC_SWITCH: begin
        next_c.st = OBWC_LATCH;
        tmr_load  = 1'b1;
        tmr_val   = ale_val(cw);
      end
      OBWC_LATCH: begin
        if (tmr_zero) begin
          if (cw[`OBWC_SDLY]) begin
            next_c.st = OBWC_DELAY;
          end else begin
            next_c.st = OBWC_STROBE;
            tmr_load  = 1'b1;
            tmr_val   = strobe_val(cw);
          end
        end
      end
      OBWC_DELAY: begin
        next_c.st = OBWC_STROBE;
        tmr_load  = 1'b1;
        tmr_val   = strobe_val(cw);
      end
      OBWC_STROBE: begin
        if (strobe_end) begin
          if (!c.wr) begin
            next_c.rdata = per_rdata;
          end
          next_c.st = cw[`OBWC_FDLY] ? OBWC_FLOAT
                                     : OBWC_DONE;
        end
      end
      OBWC_FLOAT: begin
        next_c.st = OBWC_DONE;
      end
      OBWC_DONE: begin
        next_c.st         = OBWC_IDLE;
        next_c.last_valid = 1'b1;
        next_c.last_win   = c.win;
        next_c.last_bsw   = cw[`OBWC_BSW];
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      c <= '{st:         OBWC_IDLE,
             win:        1'b0,
             wr:         1'b0,
             last_valid: 1'b0,
             last_win:   1'b0,
             last_bsw:   1'b0,
             ctrl:       {`OBWC_CTRL_RST, `OBWC_CTRL_RST},
             sel:        {`OBWC_SEL_RST, `OBWC_SEL_RST},
             addr:       24'h000000,
             wdata:      `OBWC_ZERO16,
             rdata:      `OBWC_ZERO16,
             sfr_rdata:  `OBWC_ZERO16,
             ext_go:     1'b0};
    end else begin
      c <= next_c;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign active = (c.st == OBWC_LATCH) || (c.st == OBWC_DELAY)
                  || (c.st == OBWC_STROBE) || (c.st == OBWC_FLOAT);

  always_comb begin
    per_cs = 2'h0;
    if (active) begin
      per_cs = c.win ? 2'h2 : 2'h1;
    end
  end

  assign sfr_rdata = c.sfr_rdata;
  assign acc_ready = (c.st == OBWC_IDLE);
  assign acc_hit   = dec_hit;
  assign acc_done  = (c.st == OBWC_DONE);
  assign acc_rdata = c.rdata;
  assign per_ale   = (c.st == OBWC_LATCH);
  assign per_rd    = (c.st == OBWC_STROBE) && !c.wr;
  // The early write bit drops the write strobe in the final period.
  assign per_wr    = (c.st == OBWC_STROBE) && c.wr
                     && !(cw[`OBWC_EWR] && strobe_end);
  assign per_wide  = (cw[`OBWC_WIDTH] == `OBWC_W16);
  assign per_float = (c.st == OBWC_SWITCH) || (c.st == OBWC_FLOAT);
  assign per_addr  = c.addr;
  assign per_wdata = c.wdata;
  assign ext_quiet = (c.st != OBWC_IDLE);
  assign ext_go    = c.ext_go;

  // ****************************************
  // Checks
  // ****************************************
  logic [4:0] scnt;

  always_ff @(posedge ref_clk) begin
    if (srst || (c.st != OBWC_STROBE)) begin
      scnt <= `OBWC_ZERO5;
    end else begin
      scnt <= scnt + 5'h01;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence s_switch;
    per_float ##1 per_ale;
  endsequence

  sequence s_ale_long;
    per_ale ##1 per_ale ##1 !per_ale;
  endsequence

  sequence s_go;
    acc_ready && acc_req && dec_hit;
  endsequence

  reset_clear_a: assert property (
    $past(srst) |-> (c.ctrl == 32'h0000_0000) && (per_cs == 2'h0))
    else $error("Control registers not cleared by reset.");

  switch_wait_a: assert property (
    s_go and need_sw |=> s_switch)
    else $error("Missing bus switch wait cycle.");

  no_switch_a: assert property (
    s_go and !need_sw |=> per_ale && !per_float)
    else $error("Unexpected bus switch wait cycle.");

  ale_long_a: assert property (
    $rose(per_ale) && cw[`OBWC_ALEL] |-> s_ale_long)
    else $error("Latch phase not lengthened.");

  strobe_len_a: assert property (
    (c.st == OBWC_STROBE) && strobe_end && !cw[`OBWC_RDY]
      |-> scnt == ({1'b0, cw[`OBWC_WAIT]} + `OBWC_STRB_BASE))
    else $error("Strobe length differs from wait field.");

  strobe_dly_a: assert property (
    per_ale && tmr_zero && cw[`OBWC_SDLY]
      |=> !per_rd && !per_wr ##1 (c.st == OBWC_STROBE))
    else $error("Strobe delay cycle missing.");

  float_dly_a: assert property (
    (c.st == OBWC_STROBE) && strobe_end && cw[`OBWC_FDLY]
      |=> per_float && !acc_done ##1 acc_done)
    else $error("Float delay cycle missing.");

  early_wr_a: assert property (
    $fell(per_wr) |-> ((c.st == OBWC_STROBE) == cw[`OBWC_EWR]))
    else $error("Write strobe end timing wrong.");

  ready_hold_a: assert property (
    (c.st == OBWC_STROBE) && cw[`OBWC_RDY] && !per_ready
      |=> (c.st == OBWC_STROBE))
    else $error("Strobe ended without ready.");

  cs_enable_a: assert property (
    per_cs != 2'h0 |->
      (per_cs & {c.ctrl[1][`OBWC_WEN], c.ctrl[0][`OBWC_WEN]}) == per_cs)
    else $error("Chip select on a disabled window.");

  size_ok_a: assert property (
    s_go |-> c.sel[dec_win][`OBWC_SIZE] <= `OBWC_SIZE_MAX)
    else $error("Reserved size code produced a match.");

  top_bit_a: assert property (
    (c.sel[1][`OBWC_SIZE] == `OBWC_SIZE_MAX)
      && c.ctrl[1][`OBWC_WEN]
      && (acc_addr[`OBWC_TOP] == c.sel[1][15]) |-> dec_hit)
    else $error("Largest window failed to match.");

  window_prio_a: assert property (
    s_go |=> !ext_go ##1 (per_cs != 2'h0) || per_float)
    else $error("Window hit leaked to external decode.");

  ext_quiet_a: assert property (
    (per_cs != 2'h0) |-> ext_quiet && !ext_go)
    else $error("External bus not held quiet.");

  bit_set_a: assert property (
    sfr_bset && !sfr_wr && (sfr_addr == `OBWC_CTRL0_ADR)
      && (sfr_bit == 4'hA) |=> c.ctrl[0][`OBWC_WEN])
    else $error("Bit set did not reach control register.");

endmodule // obwc_top

//--- obwc_regs.svh
// Register offsets, field positions and timing constants.
`ifndef OBWC_REGS_SVH
`define OBWC_REGS_SVH

// ****************************************
// Register offsets and reset values
// ****************************************
`define OBWC_CTRL0_ADR 16'hF114
`define OBWC_CTRL1_ADR 16'hF116
`define OBWC_SEL0_ADR  16'hF014
`define OBWC_SEL1_ADR  16'hF016
`define OBWC_CTRL_RST  16'h0000
`define OBWC_SEL_RST   16'h0000
`define OBWC_CTRL_MASK 16'h1FFF
`define OBWC_SEL_MASK  16'hFFFF
`define OBWC_ZERO16    16'h0000

// ****************************************
// Control register fields
// ****************************************
`define OBWC_WAIT  3:0
`define OBWC_SDLY  4
`define OBWC_FDLY  5
`define OBWC_WIDTH 7:6
`define OBWC_EWR   8
`define OBWC_ALEL  9
`define OBWC_WEN   10
`define OBWC_BSW   11
`define OBWC_RDY   12

// ****************************************
// Selector fields and decode constants
// ****************************************
`define OBWC_SIZE     3:0
`define OBWC_START    15:4
`define OBWC_PAGE     23:12
`define OBWC_TOP      23
`define OBWC_SIZE_MAX 4'hB
`define OBWC_W16      2'h2

// ****************************************
// Cycle timing in clock periods
// ****************************************
`define OBWC_STRB_BASE 5'h01
`define OBWC_ALE_XTRA  5'h01
`define OBWC_RDY_MIN   5'h01
`define OBWC_ZERO5     5'h00

`endif

//--- obwc_pkg.sv
// Types shared by the peripheral bus window controller.
package obwc_pkg;

  typedef enum logic [6:0] {
    OBWC_IDLE   = 7'h01,
    OBWC_SWITCH = 7'h02,
    OBWC_LATCH  = 7'h04,
    OBWC_DELAY  = 7'h08,
    OBWC_STROBE = 7'h10,
    OBWC_FLOAT  = 7'h20,
    OBWC_DONE   = 7'h40
  } obwc_state_e;

  typedef struct packed {
    logic [4:0] cnt;
  } obwc_tmr_s;

  typedef struct packed {
    obwc_state_e      st;
    logic             win;
    logic             wr;
    logic             last_valid;
    logic             last_win;
    logic             last_bsw;
    logic [1:0][15:0] ctrl;
    logic [1:0][15:0] sel;
    logic [23:0]      addr;
    logic [15:0]      wdata;
    logic [15:0]      rdata;
    logic [15:0]      sfr_rdata;
    logic             ext_go;
  } obwc_core_s;

endpackage

//--- obwc_cycle_timer.sv
// Down counter that times the address and strobe phases.
`timescale 1ns/1ps
`include "obwc_regs.svh"

module obwc_cycle_timer import obwc_pkg::*; (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       srst,
  // Load control
  input  wire logic       load,
  input  wire logic [4:0] load_val,
  // Status
  output logic            zero
);

  obwc_tmr_s tmr;
  obwc_tmr_s next_tmr;

  always_comb begin
    next_tmr = tmr;
    if (load) begin
      next_tmr.cnt = load_val;
    end else if (tmr.cnt != `OBWC_ZERO5) begin
      next_tmr.cnt = tmr.cnt - 5'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tmr <= '{cnt: `OBWC_ZERO5};
    end else begin
      tmr <= next_tmr;
    end
  end

  assign zero = (tmr.cnt == `OBWC_ZERO5);

endmodule // obwc_cycle_timer

//--- obwc_window_decode.sv
// Address window match for the two wide-range selectors.
`timescale 1ns/1ps
`include "obwc_regs.svh"

module obwc_window_decode import obwc_pkg::*; (
  // Access address
  input  wire logic [23:0] addr,
  // Window programming
  input  wire logic [15:0] sel0,
  input  wire logic [15:0] sel1,
  input  wire logic [15:0] ctrl0,
  input  wire logic [15:0] ctrl1,
  // Result
  output logic             hit,
  output logic             win
);

  // Bits below the window size are ignored; reserved sizes never hit.
  function automatic logic win_match(input logic [23:0] a,
                                     input logic [15:0] s,
                                     input logic [15:0] c);
    logic [11:0] mask;
    mask = 12'hFFF << s[`OBWC_SIZE];
    win_match = c[`OBWC_WEN]
      && (s[`OBWC_SIZE] <= `OBWC_SIZE_MAX)
      && (((a[`OBWC_PAGE] ^ s[`OBWC_START]) & mask) == 12'h000);
  endfunction

  logic m0;
  logic m1;

  always_comb begin
    m0  = win_match(addr, sel0, ctrl0);
    m1  = win_match(addr, sel1, ctrl1);
    hit = m0 | m1;
    win = !m0;
  end

endmodule // obwc_window_decode

//--- obwc_periph_model.sv
// Behavioural pair of on-chip peripherals on the window bus.
`timescale 1ns/1ps

module obwc_periph_model import obwc_pkg::*; (
  // Clock
  input  wire logic        ref_clk,
  // Window bus
  input  wire logic [1:0]  per_cs,
  input  wire logic        per_rd,
  input  wire logic        per_wr,
  input  wire logic [15:0] per_wdata,
  output logic [15:0]      per_rdata,
  output logic             per_ready,
  // Strobe cycles before ready rises
  input  wire logic [3:0]  lag
);
  logic [1:0][15:0] mem  = '0;
  logic [3:0]       cnt  = '0;
  logic [15:0]      last = '0;
  logic             stb;

  assign stb = per_rd | per_wr;

  // Each chip select line owns its own storage word.
  always @(posedge ref_clk) begin
    cnt <= stb ? cnt + 4'h1 : 4'h0;
    if (per_wr && per_cs[0]) begin
      mem[0] <= per_wdata;
    end
    if (per_wr && per_cs[1]) begin
      mem[1] <= per_wdata;
    end
    if (per_rd) begin
      last <= per_rdata;
    end
  end

  assign per_ready = stb && (cnt >= lag);
  // Outside a read the data lines show the inverse of the last word.
  assign per_rdata = per_rd ? mem[per_cs[1]] : ~last;
endmodule // obwc_periph_model

//--- obwc_top_tb.sv
// Self-checking bench for the peripheral bus window controller.
`timescale 1ns/1ps
`include "obwc_regs.svh"

module obwc_top_tb import obwc_pkg::*;;
  // ********
  // Signals
  // ********
  logic        ref_clk   = 1'b0;
  logic        srst      = 1'b1;
  logic [15:0] sfr_addr  = '0;
  logic        sfr_wr    = 1'b0;
  logic [15:0] sfr_wdata = '0;
  logic        sfr_bset  = 1'b0;
  logic        sfr_bclr  = 1'b0;
  logic [3:0]  sfr_bit   = '0;
  logic        sfr_rd    = 1'b0;
  logic        acc_req   = 1'b0;
  logic [23:0] acc_addr  = '0;
  logic        acc_write = 1'b0;
  logic [15:0] acc_wdata = '0;
  logic [3:0]  lag       = '0;
  logic [15:0] sfr_rdata, acc_rdata, per_wdata, per_rdata;
  logic        acc_ready, acc_hit, acc_done, per_ale, per_rd, per_wr;
  logic        per_wide, per_float, per_ready, ext_quiet, ext_go;
  logic [1:0]  per_cs, cs;
  logic [23:0] per_addr, pa;
  logic        hit, go, wide, exp_hit;
  int          n, ale_n, stb_n, flt_n, loud, busy;
  int          mismatches = 0;
  int          compares   = 0;
  // Control, lag, cycles, latch, strobe, float, wide.
  int          ct [10][7] = '{'{'h0400, 0, 4, 1, 2, 0, 0},
    '{'h0403, 0, 7, 1, 5, 0, 0}, '{'h0410, 0, 5, 1, 2, 0, 0},
    '{'h0420, 0, 5, 1, 2, 1, 0}, '{'h0600, 0, 5, 2, 2, 0, 0},
    '{'h0480, 0, 4, 1, 2, 0, 1}, '{'h04C0, 0, 4, 1, 2, 0, 0},
    '{'h0500, 0, 4, 1, 1, 0, 0}, '{'h1403, 5, 8, 1, 6, 0, 0},
    '{'h1403, 0, 4, 1, 2, 0, 0}};
  logic [23:0] ad [8] = '{24'h5A5000, 24'h5A4FFF, 24'h5A6000, 24'h5A5FFF,
                          24'h400000, 24'h7FFFFF, 24'h800000, 24'h100ABC};
  logic [23:0] sw [4] = '{24'h100000, 24'h200000, 24'h200000, 24'h100000};
  int          sn [4] = '{4, 5, 4, 4};

  always #4 ref_clk = ~ref_clk;

  obwc_top i_dut (.ref_clk(ref_clk), .srst(srst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_bset(sfr_bset),
    .sfr_bclr(sfr_bclr), .sfr_bit(sfr_bit), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .acc_req(acc_req), .acc_addr(acc_addr),
    .acc_write(acc_write), .acc_wdata(acc_wdata), .acc_ready(acc_ready),
    .acc_hit(acc_hit), .acc_done(acc_done), .acc_rdata(acc_rdata),
    .per_cs(per_cs), .per_ale(per_ale), .per_rd(per_rd), .per_wr(per_wr),
    .per_wide(per_wide), .per_float(per_float), .per_addr(per_addr),
    .per_wdata(per_wdata), .per_rdata(per_rdata), .per_ready(per_ready),
    .ext_quiet(ext_quiet), .ext_go(ext_go));

  obwc_periph_model i_per (.ref_clk(ref_clk), .per_cs(per_cs),
    .per_rd(per_rd), .per_wr(per_wr), .per_wdata(per_wdata),
    .per_rdata(per_rdata), .per_ready(per_ready), .lag(lag));

  // ********
  // Tasks
  // ********
  function automatic logic hit_of(input logic [15:0] s,
                                  input logic [23:0] a);
    return (s[3:2] != 2'b11)
      && ((a[23:12] >> s[3:0]) == (s[15:4] >> s[3:0]));
  endfunction

  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_n(input int got, input int exp);
    compares++;
    if (got != exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
  endtask

  task automatic bop(input logic [3:0] b, input logic s);
    @(posedge ref_clk);
    sfr_addr <= `OBWC_CTRL0_ADR;
    sfr_bit <= b;
    sfr_bset <= s;
    sfr_bclr <= ~s;
    @(posedge ref_clk);
    sfr_bset <= 1'b0;
    sfr_bclr <= 1'b0;
  endtask

  task automatic rdc(input logic [15:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge ref_clk);
    sfr_rd <= 1'b0;
    #1;
    cmp(24'(sfr_rdata), 24'(e));
  endtask

  task automatic probe(input logic [23:0] a, input logic e);
    @(posedge ref_clk);
    acc_addr <= a;
    #1;
    cmp(24'(acc_hit), 24'(e));
  endtask

  // Runs one access and records what the window bus showed.
  task automatic acc(input logic [23:0] a, input logic w,
                     input logic [15:0] d);
    @(posedge ref_clk);
    acc_addr <= a;
    acc_write <= w;
    acc_wdata <= d;
    acc_req <= 1'b1;
    #1;
    hit = acc_hit;
    @(posedge ref_clk);
    acc_req <= 1'b0;
    {cs, go, wide} = '0;
    ale_n = 0;
    stb_n = 0;
    flt_n = 0;
    loud = 0;
    busy = 0;
    pa = '0;
    for (n = 1; n < 64; n++) begin
      #1;
      cs |= per_cs;
      go |= ext_go;
      wide |= per_wide;
      ale_n += int'(per_ale);
      stb_n += int'(w ? per_wr : per_rd);
      flt_n += int'(per_float);
      loud += int'(per_cs != 2'b00 && ext_quiet !== 1'b1);
      busy += int'(hit && acc_ready !== 1'b0);
      if (per_ale === 1'b1) begin
        pa = per_addr;
      end
      if (acc_done === 1'b1 || !hit) begin
        break;
      end
      @(posedge ref_clk);
    end
    if (n == 64) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, n, 63);
    end
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic finish_test;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ********
  // Tests
  // ********
  initial begin
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    rdc(`OBWC_CTRL0_ADR, 16'h0000);
    rdc(`OBWC_CTRL1_ADR, 16'h0000);
    rdc(`OBWC_SEL0_ADR, 16'h0000);
    rdc(`OBWC_SEL1_ADR, 16'h0000);
    rdc(16'hF118, 16'h0000);
    acc(24'h000000, 1'b1, 16'h5555);
    cmp(24'(go), 24'h1);
    cmp(24'(cs), 24'h0);
    wr(`OBWC_CTRL0_ADR, 16'hFFFF);
    rdc(`OBWC_CTRL0_ADR, 16'h1FFF);
    bop(4'hA, 1'b0);
    rdc(`OBWC_CTRL0_ADR, 16'h1BFF);
    bop(4'hA, 1'b1);
    rdc(`OBWC_CTRL0_ADR, 16'h1FFF);
    wr(`OBWC_SEL0_ADR, 16'h1000);
    for (int i = 0; i < 10; i++) begin
      wr(`OBWC_CTRL0_ADR, 16'(ct[i][0]));
      lag <= 4'(ct[i][1]);
      acc(24'h100ABC, 1'b1, 16'hA5C0 ^ 16'(i));
      cmp_n(n, ct[i][2]);
      cmp_n(ale_n, ct[i][3]);
      cmp_n(stb_n, ct[i][4]);
      cmp_n(flt_n, ct[i][5]);
      cmp(24'(wide), 24'(ct[i][6]));
      cmp(pa, 24'h100ABC);
      acc(24'h100ABC, 1'b0, 16'h0000);
      cmp(24'(acc_rdata), 24'hA5C0 ^ 24'(i));
      cmp(24'(cs), 24'h1);
      cmp_n(loud, 0);
      cmp(24'(go), 24'h0);
      cmp_n(busy, 0);
    end
    wr(`OBWC_CTRL0_ADR, 16'h0000);
    wr(`OBWC_CTRL1_ADR, 16'h0400);
    for (int s = 0; s < 16; s++) begin
      wr(`OBWC_SEL1_ADR, {12'h5A5, 4'(s)});
      foreach (ad[j]) begin
        exp_hit = hit_of({12'h5A5, 4'(s)}, ad[j]);
        probe(ad[j], exp_hit);
      end
    end
    wr(`OBWC_CTRL0_ADR, 16'h0C00);
    wr(`OBWC_SEL1_ADR, 16'h2000);
    foreach (sw[j]) begin
      acc(sw[j], 1'b1, 16'h0F0F);
      cmp_n(n, sn[j]);
      cmp(pa, sw[j]);
    end
    finish_test();
  end

  initial begin
    #100us;
    mismatches++;
    finish_test();
  end
endmodule // obwc_top_tb
